//--- verilog/pin_routing_map.vh
`ifndef PIN_ROUTING_MAP_VH
`define PIN_ROUTING_MAP_VH

// Pin space is port * 16 + pin, so a select value is the flat pin index
`define NUM_PINS        64
`define PINS_PER_PORT   16
`define SEL_W           6
`define SEL_PIN_LSB     0
`define SEL_PIN_MSB     3
`define SEL_PORT_LSB    4
`define SEL_PORT_MSB    5

// Port field codes
`define PORT_A          2'h0
`define PORT_B          2'h1
`define PORT_C          2'h2
`define PORT_D          2'h3

// Digital routable resources and the bus each one can reach
`define NUM_RES         8
`define RES_REACH_AB    8'h3b
`define RES_REACH_CD    8'h37

// Fixed resources and the single pin each is wired to
`define NUM_FIXED       2
`define FIXED0_PIN      6'h31
`define FIXED1_PIN      6'h30

// Analog peripherals and allocation field layout
`define NUM_ANA         4
`define ALLOC_W         16
`define ALLOC_ID_W      4
`define ALLOC_NONE      4'h0
`define EVEN_FIRST_LSB  0
`define EVEN_SECOND_LSB 4
`define ODD_FIRST_LSB   8
`define ODD_SECOND_LSB  12

// Reset values
`define PIN_RESET       64'h0000_0000_0000_0000
`define RES_IN_RESET    8'h00

`endif

//--- verilog/route_slot.v
`include "pin_routing_map.vh"
`default_nettype none

// One digital resource: decodes its pin select into a one-hot pin mask
module route_slot #(
  parameter REACH_AB = 1'b1,
  parameter REACH_CD = 1'b1
) (
  input  wire [`SEL_W-1:0]    pin_select,
  input  wire                 route_enable,
  output reg  [`NUM_PINS-1:0] pin_hit
);

  reg [6:0] p;
  reg       reach;

  always @*
  begin
    pin_hit = `PIN_RESET;
    // Ports A/B sit on one digital bus, C/D on the other
    if (pin_select[`SEL_PORT_MSB:`SEL_PORT_LSB] == `PORT_A ||
        pin_select[`SEL_PORT_MSB:`SEL_PORT_LSB] == `PORT_B)
      reach = REACH_AB; // R3 R4
    else
      reach = REACH_CD; // R3 R4
    for (p = 7'd0; p < 7'd64; p = p + 7'd1)
    begin
      // Any pin of a reachable port may be selected
      if (route_enable && reach && pin_select == p[5:0]) // R2 R6 R16
        pin_hit[p[5:0]] = 1'b1;
    end
  end

endmodule // route_slot

`default_nettype wire

//--- verilog/pin_routing_matrix.v
// Summary of operation
// R1: Fixed resources are wired to one pin each, never through the matrix.
// R2: Digital bus connects any routable resource to any pin of its ports.
// R3: Two digital buses: one for ports A and B, one for C and D.
// R4: Some resources reach only one digital bus.
// R5: Each resource has a port and pin select; port A is 0, B 1, C 2.
// R6: Connection happens only once the resource route enable bit is set.
// R7: Software configures each routed pin mode to suit its resource.
// R8: Three analog buses: port A, port B, and shared ports C and D.
// R9: No analog connection without a matching grant in the bus allocation.
// R10: Each analog bus admits two peripherals on even and two on odd pins.
// R11: Either even field grants even pins; either odd field grants odd pins.
// R12: Differential: positive on even, negative on odd; single ended: any pin.
// R13: One analog peripheral may hold grants on any number of buses.
// R14: Two peripherals on the same pin are both connected at once.
// R15: Software sets pin input disabled, then grants, then selects the channel.
// R16: A disabled resource neither drives a pin nor receives one.
`include "pin_routing_map.vh"
`default_nettype none

module pin_routing_matrix (
  input  wire                          ref_clk,
  input  wire                          rst,
  // Ordinary GPIO drive, used wherever no resource claims the pin
  input  wire [`NUM_PINS-1:0]          gpio_out,
  input  wire [`NUM_PINS-1:0]          gpio_oe,
  // Package pins
  input  wire [`NUM_PINS-1:0]          pin_in,
  output reg  [`NUM_PINS-1:0]          pin_out,
  output reg  [`NUM_PINS-1:0]          pin_oe,
  output reg  [`NUM_PINS-1:0]          pin_value,
  output reg  [`NUM_PINS-1:0]          pin_claimed,
  // Digital routable resources
  input  wire [`NUM_RES*`SEL_W-1:0]    resource_pin_select,
  input  wire [`NUM_RES-1:0]           peripheral_route_enable,
  input  wire [`NUM_RES-1:0]           res_out,
  input  wire [`NUM_RES-1:0]           res_oe,
  output reg  [`NUM_RES-1:0]           res_in,
  // Fixed resources
  input  wire [`NUM_FIXED-1:0]         fixed_enable,
  input  wire [`NUM_FIXED-1:0]         fixed_out,
  input  wire [`NUM_FIXED-1:0]         fixed_oe,
  output reg  [`NUM_FIXED-1:0]         fixed_in,
  // Analog bus allocation
  input  wire [`ALLOC_W-1:0]           analog_bus_port_a,
  input  wire [`ALLOC_W-1:0]           analog_bus_port_b,
  input  wire [`ALLOC_W-1:0]           analog_bus_ports_c_d,
  // Analog peripheral channel requests
  input  wire [`NUM_ANA*`SEL_W-1:0]    ana_pos_select,
  input  wire [`NUM_ANA-1:0]           ana_pos_request,
  input  wire [`NUM_ANA*`SEL_W-1:0]    ana_neg_select,
  input  wire [`NUM_ANA-1:0]           ana_neg_request,
  input  wire [`NUM_ANA-1:0]           ana_differential,
  output reg  [`NUM_ANA*`NUM_PINS-1:0] ana_pos_switch,
  output reg  [`NUM_ANA*`NUM_PINS-1:0] ana_neg_switch
);

  // Pin input synchroniser
  reg  [`NUM_PINS-1:0] sync1;
  reg  [`NUM_PINS-1:0] sync2;
  reg  [`NUM_PINS-1:0] sync3;

  wire [`NUM_RES*`NUM_PINS-1:0] hit;

  reg  [`NUM_PINS-1:0]          next_pin_out;
  reg  [`NUM_PINS-1:0]          next_pin_oe;
  reg  [`NUM_PINS-1:0]          next_claimed;
  reg  [`NUM_RES-1:0]           next_res_in;
  reg  [`NUM_FIXED-1:0]         next_fixed_in;
  reg  [`NUM_ANA*`NUM_PINS-1:0] next_pos_switch;
  reg  [`NUM_ANA*`NUM_PINS-1:0] next_neg_switch;

  reg  [5:0]                fixed_pin [0:`NUM_FIXED-1];
  reg  [`ALLOC_W-1:0]       alloc;
  reg  [`ALLOC_ID_W-1:0]    id;
  reg  [`SEL_W-1:0]         pos_sel;
  reg  [`SEL_W-1:0]         neg_sel;
  reg                       even_ok;
  reg                       odd_ok;
  reg  [6:0]                p;
  reg  [6:0]                q;
  integer                   r;
  integer                   a;
  integer                   f;

  // Reach masks as sized constants so each slot gets a one-bit flag
  localparam [`NUM_RES-1:0] REACH_AB_MASK = `RES_REACH_AB;
  localparam [`NUM_RES-1:0] REACH_CD_MASK = `RES_REACH_CD;

  genvar g;
  generate
    for (g = 0; g < `NUM_RES; g = g + 1)
    begin : slot
      route_slot #(
        .REACH_AB (REACH_AB_MASK[g]),
        .REACH_CD (REACH_CD_MASK[g])
      ) u_slot (
        .pin_select   (resource_pin_select[g*`SEL_W +: `SEL_W]), // R5
        .route_enable (peripheral_route_enable[g]),
        .pin_hit      (hit[g*`NUM_PINS +: `NUM_PINS])
      );
    end
  endgenerate

  // Digital drive and resource inputs
  always @*
  begin
    fixed_pin[0] = `FIXED0_PIN;
    fixed_pin[1] = `FIXED1_PIN;
    next_pin_out = gpio_out;
    next_pin_oe  = gpio_oe;
    next_claimed = `PIN_RESET;
    next_res_in  = `RES_IN_RESET;
    next_fixed_in = {`NUM_FIXED{1'b0}};
    for (p = 7'd0; p < 7'd64; p = p + 7'd1)
    begin
      // Descending scan so the lowest numbered resource wins a shared pin
      for (r = `NUM_RES - 1; r >= 0; r = r - 1)
      begin
        if (hit[r*`NUM_PINS + p[5:0]]) // R2 R6
        begin
          next_pin_out[p[5:0]] = res_out[r];
          next_pin_oe[p[5:0]]  = res_oe[r];
          next_claimed[p[5:0]] = 1'b1;
        end
      end
      // Fixed resources bypass the matrix and take precedence on their pin
      for (f = 0; f < `NUM_FIXED; f = f + 1)
      begin
        if (fixed_enable[f] && fixed_pin[f] == p[5:0]) // R1
        begin
          next_pin_out[p[5:0]] = fixed_out[f];
          next_pin_oe[p[5:0]]  = fixed_oe[f];
          next_claimed[p[5:0]] = 1'b1;
        end
      end
    end
    // A disabled resource has an all-zero mask, so its input reads 0
    for (r = 0; r < `NUM_RES; r = r + 1)
      next_res_in[r] = |(hit[r*`NUM_PINS +: `NUM_PINS] & pin_value); // R16
    for (f = 0; f < `NUM_FIXED; f = f + 1)
      next_fixed_in[f] = fixed_enable[f] & pin_value[fixed_pin[f]]; // R1
  end

  // Analog switch closure
  always @*
  begin
    next_pos_switch = {`NUM_ANA*`NUM_PINS{1'b0}};
    next_neg_switch = {`NUM_ANA*`NUM_PINS{1'b0}};
    alloc   = analog_bus_port_a;
    id      = `ALLOC_NONE;
    pos_sel = {`SEL_W{1'b0}};
    neg_sel = {`SEL_W{1'b0}};
    even_ok = 1'b0;
    odd_ok  = 1'b0;
    for (a = 0; a < `NUM_ANA; a = a + 1)
    begin
      // Field value 0 means an empty slot; peripheral n is coded n + 1
      id      = a[`ALLOC_ID_W-1:0] + 4'h1;
      pos_sel = ana_pos_select[a*`SEL_W +: `SEL_W];
      neg_sel = ana_neg_select[a*`SEL_W +: `SEL_W];
      for (q = 7'd0; q < 7'd64; q = q + 7'd1)
      begin
        if (q[5:4] == `PORT_A)
          alloc = analog_bus_port_a; // R8
        else if (q[5:4] == `PORT_B)
          alloc = analog_bus_port_b; // R8
        else
          alloc = analog_bus_ports_c_d; // R8
        // Each bus is looked up on its own, so grants on several buses stack
        even_ok = alloc[`EVEN_FIRST_LSB +: `ALLOC_ID_W] == id ||
                  alloc[`EVEN_SECOND_LSB +: `ALLOC_ID_W] == id; // R10 R11 R13
        odd_ok  = alloc[`ODD_FIRST_LSB +: `ALLOC_ID_W] == id ||
                  alloc[`ODD_SECOND_LSB +: `ALLOC_ID_W] == id; // R10 R11 R13
        // Switches are per peripheral, so a shared pin closes both at once
        if (ana_pos_request[a] && pos_sel == q[5:0] &&
            (q[0] ? odd_ok : even_ok) &&
            (!ana_differential[a] || !q[0])) // R9 R12 R14
          next_pos_switch[a*`NUM_PINS + q[5:0]] = 1'b1;
        if (ana_neg_request[a] && ana_differential[a] && neg_sel == q[5:0] &&
            q[0] && odd_ok) // R9 R12 R14
          next_neg_switch[a*`NUM_PINS + q[5:0]] = 1'b1;
      end
    end
  end

  // Change is accepted only when the second and third stages agree
  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      sync1     <= `PIN_RESET;
      sync2     <= `PIN_RESET;
      sync3     <= `PIN_RESET;
      pin_value <= `PIN_RESET;
    end
    else
    begin
      sync1     <= pin_in;
      sync2     <= sync1;
      sync3     <= sync2;
      pin_value <= (sync2 & sync3) | (pin_value & (sync2 ^ sync3));
    end
  end

  // Registered outputs; during reset no pin is driven
  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      pin_out        <= `PIN_RESET;
      pin_oe         <= `PIN_RESET;
      pin_claimed    <= `PIN_RESET;
      res_in         <= `RES_IN_RESET;
      fixed_in       <= {`NUM_FIXED{1'b0}};
      ana_pos_switch <= {`NUM_ANA*`NUM_PINS{1'b0}};
      ana_neg_switch <= {`NUM_ANA*`NUM_PINS{1'b0}};
    end
    else
    begin
      pin_out        <= next_pin_out;
      pin_oe         <= next_pin_oe; // R16
      pin_claimed    <= next_claimed;
      res_in         <= next_res_in;
      fixed_in       <= next_fixed_in;
      ana_pos_switch <= next_pos_switch;
      ana_neg_switch <= next_neg_switch;
    end
  end

endmodule // pin_routing_matrix

`default_nettype wire

//--- tb/pin_far_side.sv
`default_nettype none
module pin_far_side (
  input  wire logic [63:0] pin_out,
  input  wire logic [63:0] pin_oe,
  input  wire logic [63:0] ext_en,
  input  wire logic [63:0] ext_val,
  output logic      [63:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // Released pins fall to the pull-up so a stale value never reads back
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val) | ~(pin_oe | ext_en);
endmodule // pin_far_side
`default_nettype wire

//--- tb/pin_routing_matrix_asserts.sv
`default_nettype none
module pin_routing_matrix_asserts (
  input wire logic         ref_clk,
  input wire logic         rst,
  input wire logic [63:0]  gpio_oe,
  input wire logic [63:0]  pin_oe,
  input wire logic [63:0]  pin_claimed,
  input wire logic [47:0]  resource_pin_select,
  input wire logic [7:0]   peripheral_route_enable,
  input wire logic [7:0]   res_oe,
  input wire logic [1:0]   fixed_enable,
  input wire logic [1:0]   fixed_oe,
  input wire logic [15:0]  analog_bus_port_a,
  input wire logic [23:0]  ana_pos_select,
  input wire logic [3:0]   ana_pos_request,
  input wire logic [3:0]   ana_differential,
  input wire logic [255:0] ana_pos_switch,
  input wire logic [255:0] ana_neg_switch
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  route_drive_a: assert property (
    peripheral_route_enable == 8'h01 && fixed_enable == 2'h0 |=>
    pin_claimed == 64'h1 << $past(resource_pin_select[5:0]) &&
    (pin_oe & pin_claimed) == {63'h0, $past(res_oe[0])} << $past(resource_pin_select[5:0]))
    else $error("routed pin not driven by resource");
  idle_gpio_a: assert property (
    peripheral_route_enable == 8'h00 && fixed_enable == 2'h0 |=>
    pin_claimed == 64'h0 && pin_oe == $past(gpio_oe)) else $error("idle pin not under gpio");
  reach_limit_a: assert property (
    fixed_enable == 2'h0 && (peripheral_route_enable == 8'h08 && resource_pin_select[23] ||
    peripheral_route_enable == 8'h04 && !resource_pin_select[17]) |=> pin_claimed == 64'h0)
    else $error("resource reached a bus it lacks");
  fixed_pin_a: assert property (
    fixed_enable[0] |=> pin_claimed[49] && pin_oe[49] == $past(fixed_oe[0]))
    else $error("fixed resource not on its pin");
  pos_grant_a: assert property (
    ana_pos_switch[1] |-> $past(ana_pos_request[0]) && !$past(ana_differential[0]) &&
    $past(ana_pos_select[5:0]) == 6'h01 && ($past(analog_bus_port_a[11:8]) == 4'h1 ||
    $past(analog_bus_port_a[15:12]) == 4'h1))
    else $error("analog switch closed without grant");
  neg_odd_a: assert property (
    (ana_neg_switch & {128{2'b01}}) == 256'h0) else $error("negative input on even pin");
  diff_pos_a: assert property (
    $past(ana_differential[1]) && $past(ana_pos_select[11:6]) == 6'h03 |-> !ana_pos_switch[67])
    else $error("differential positive on odd pin");
  shared_pin_a: assert property (
    ana_pos_request[1:0] == 2'h3 && ana_pos_select[11:0] == 12'h082 &&
    ana_differential[1:0] == 2'h0 && analog_bus_port_a[7:0] == 8'h21 |=>
    ana_pos_switch[2] && ana_pos_switch[66]) else $error("shared pin not joined");
endmodule // pin_routing_matrix_asserts

bind pin_routing_matrix pin_routing_matrix_asserts chk (.ref_clk, .rst, .gpio_oe, .pin_oe,
  .pin_claimed, .resource_pin_select, .peripheral_route_enable, .res_oe, .fixed_enable,
  .fixed_oe, .analog_bus_port_a, .ana_pos_select, .ana_pos_request, .ana_differential,
  .ana_pos_switch, .ana_neg_switch);
`default_nettype wire

//--- tb/testbench.sv
`include "pin_routing_map.vh"
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic         ref_clk, rst, ok, lvl;
  logic [1:0]   drv;
  logic [63:0]  gpio_out, gpio_oe, pin_in, pin_out, pin_oe, claim, ext_en, ext_val, pv;
  logic [47:0]  sel;
  logic [7:0]   ren, rout, roe, rin;
  logic [1:0]   fen, fout, foe, fin;
  logic [15:0]  al_a, al_b, al_cd, al;
  logic [23:0]  psel, nsel;
  logic [3:0]   preq, nreq, diff;
  logic [255:0] psw, nsw;
  logic [5:0]   p;
  int           bad_count, compares, r;

  pin_routing_matrix dut (.ref_clk, .rst, .gpio_out, .gpio_oe, .pin_in, .pin_out, .pin_oe,
    .pin_value(pv), .pin_claimed(claim), .resource_pin_select(sel),
    .peripheral_route_enable(ren), .res_out(rout), .res_oe(roe), .res_in(rin),
    .fixed_enable(fen), .fixed_out(fout), .fixed_oe(foe), .fixed_in(fin),
    .analog_bus_port_a(al_a), .analog_bus_port_b(al_b), .analog_bus_ports_c_d(al_cd),
    .ana_pos_select(psel), .ana_pos_request(preq), .ana_neg_select(nsel),
    .ana_neg_request(nreq), .ana_differential(diff), .ana_pos_switch(psw),
    .ana_neg_switch(nsw));
  pin_far_side far (.pin_out, .pin_oe, .ext_en, .ext_val, .pin_in);

  function automatic logic reach(input int r, input logic [5:0] p);
    logic [7:0] m;
    m = p[5] ? `RES_REACH_CD : `RES_REACH_AB;
    return m[r];
  endfunction

  task automatic chk(input logic [71:0] got, input logic [71:0] exp, input string what);
    compares++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic tally_and_finish;
    if (bad_count == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Inputs move 1 ns after the edge so no race with the sampling edge
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  initial
  begin
    #50000;
    bad_count++;
    tally_and_finish;
  end

  initial
  begin
    {sel, ren, rout, roe, fen, fout, foe, al_a, al_b, al_cd, psel, nsel, preq, nreq, diff} = '0;
    rst = 1'b1;
    ext_en = '1;
    void'($urandom(21804));
    gpio_out = {$urandom, $urandom};
    gpio_oe = {$urandom, $urandom};
    ext_val = {$urandom, $urandom};
    cyc(3);
    chk({rin, pin_oe}, 72'h0, "reset");
    rst = 1'b0;
    repeat (64)
    begin
      r = $urandom % 8;
      p = 6'($urandom);
      rout = 8'($urandom);
      roe = 8'($urandom);
      ok = reach(r, p);
      drv = ok ? {roe[r], rout[r]} : {gpio_oe[p], gpio_out[p]};
      lvl = drv[1] ? drv[0] : ext_val[p];
      sel[6*r +: 6] = p;
      cyc(1);
      chk(claim, 72'h0, "early");
      ren[r] = 1'b1;
      cyc(1);
      chk(claim, 64'(ok) << p, "claim");
      chk({pin_oe[p], pin_out[p]}, drv, "drv");
      // Pin level needs three sync stages, the agree filter and the output register
      cyc(5);
      chk(pv[p], lvl, "level");
      chk(rin, 8'(ok && lvl) << r, "input");
      ren = '0;
      cyc(2);
      chk({rin, claim}, 72'h0, "off");
    end
    sel[5:0] = 6'h31;
    ren = 8'h01;
    fen = 2'h3;
    foe = 2'h3;
    fout = 2'($urandom);
    cyc(6);
    chk({fin, pin_oe[49:48], pin_out[49:48]}, {fout, 2'h3, fout[0], fout[1]}, "fixed");
    fen = '0;
    ren = '0;
    for (int rep = 0; rep < 2; rep++)
      for (int a = 0; a < 4; a++)
        for (int b = 0; b < 3; b++)
          for (int k = 0; k < 2; k++)
          begin
            p = 6'(16 * b + 2 * a + k);
            al = 16'(a + 1) << (8 * k + 4 * ($urandom % 2));
            {al_a, al_b, al_cd} = {3{al}};
            cyc(1);
            psel[6*a +: 6] = p;
            nsel[6*a +: 6] = p;
            preq[a] = 1'b1;
            nreq[a] = 1'b1;
            diff[a] = rep[0];
            cyc(1);
            chk(psw[64*a +: 64], 64'(!(rep && k)) << p, "pos");
            chk(nsw[64*a +: 64], 64'(rep && k) << p, "neg");
            {al_a, al_b, al_cd} = {3{al}} & ~(48'hffff << (32 - 16 * b));
            cyc(1);
            chk(psw[64*a +: 64] | nsw[64*a +: 64], 72'h0, "ungranted");
            preq = '0;
            nreq = '0;
          end
    diff = '0;
    psel = 24'h00_0082;
    preq = 4'h3;
    {al_a, al_b, al_cd} = 48'h0021_0000_0000;
    cyc(2);
    chk({psw[66], psw[2]}, 72'h3, "shared");
    tally_and_finish;
  end
endmodule // testbench
`default_nettype wire
